/* File: rtl/pafs_top.sv */
`timescale 1ns/10ps
`default_nettype none
`include "pafs_map.svh"
// Port A pin function select with APB register access
module pafs_top (
  // Clock, reset, enable
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         ce,
  // APB slave
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [31:0]  paddr,
  input  wire logic [31:0]  pwdata,
  output var  logic [31:0]  prdata,
  output var  logic         pready,
  output var  logic         pslverr,
  // Port data and direction from the port registers
  input  wire pafs_pkg::pafs_word_t port_data,
  input  wire pafs_pkg::pafs_word_t port_dir,
  // Pins
  input  wire pafs_pkg::pafs_word_t pad_in,
  output var  pafs_pkg::pafs_word_t pad_out,
  output var  pafs_pkg::pafs_word_t pad_oe,
  // Peripheral inputs fed from pins
  output var  logic         ext_int_0,
  output var  logic         ext_int_1,
  output var  logic         ext_int_2,
  output var  logic         ext_int_3,
  output var  logic         dma_req_0,
  output var  logic         dma_req_1,
  output var  logic         timer_ext_clk_a,
  output var  logic         timer_ext_clk_b,
  output var  logic         conv_trigger_in,
  output var  logic         bus_req_in,
  output var  logic         wait_in,
  output var  logic         upper_parity_in,
  output var  logic         lower_parity_in,
  output var  logic         timer_cc_a0_in,
  output var  logic         timer_cc_b0_in,
  output var  logic         timer_cc_a1_in,
  output var  logic         timer_cc_b1_in,
  // Peripheral outputs routed to pins
  input  wire logic         dma_ack_0,
  input  wire logic         dma_ack_1,
  input  wire logic         address_hold_out,
  input  wire logic         int_request_out,
  input  wire logic         bus_grant_out,
  input  wire logic         read_strobe_out,
  input  wire logic         high_lane_store_strobe,
  input  wire logic         low_lane_store_strobe,
  input  wire logic         chip_sel_4,
  input  wire logic         chip_sel_5,
  input  wire logic         chip_sel_6,
  input  wire logic         chip_sel_7,
  input  wire logic         row_addr_strobe,
  // Two-way peripheral lines, output half
  input  wire logic         upper_parity_out,
  input  wire logic         upper_parity_oe,
  input  wire logic         lower_parity_out,
  input  wire logic         lower_parity_oe,
  input  wire logic         timer_cc_a0_out,
  input  wire logic         timer_cc_a0_oe,
  input  wire logic         timer_cc_b0_out,
  input  wire logic         timer_cc_b0_oe,
  input  wire logic         timer_cc_a1_out,
  input  wire logic         timer_cc_a1_oe,
  input  wire logic         timer_cc_b1_out,
  input  wire logic         timer_cc_b1_oe
);
  import pafs_pkg::*;

  pafs_regs_s st_r;   // All state
  pafs_regs_s st_nxt; // Next state
  pafs_pad_if pins(); // Core-to-pad bundle

  logic hit_hi;       // Address selects the high register
  logic hit_lo;       // Address selects the low register
  logic acc_done;     // Transfer completes at this edge

  // Word-aligned compare of an index against the bus address
  function automatic logic addr_is(input logic [31:0] a, input logic [29:0] idx);
    return (a[31:2] == idx) && (a[1:0] == 2'h0);
  endfunction : addr_is

  // Keep writable bits, force read-as-one bits
  function automatic pafs_word_t merge(input pafs_word_t w, input pafs_word_t wm,
                                       input pafs_word_t ones);
    return (w & wm) | ones;
  endfunction : merge

  // Two-bit field of a register
  function automatic pafs_mode_e fld(input pafs_word_t r, input int lsb);
    return pafs_mode_e'(r[lsb +: 2]);
  endfunction : fld

  // Address decode
  assign hit_hi = addr_is(paddr, `PAFS_HI_IDX);
  assign hit_lo = addr_is(paddr, `PAFS_LO_IDX);

  // Zero-wait answer once read data has been captured
  assign pready   = ce && st_r.cap_ok;
  assign acc_done = psel && penable && pready;
  // Unmapped addresses are refused with an error, nothing stored
  assign pslverr  = psel && penable && !(hit_hi || hit_lo);
  assign prdata   = {16'h0000, st_r.rdata};

  // Register and bus state; frozen while the enable is low
  always_comb begin
    st_nxt = st_r;
    if (ce) begin
      // Capture read data on every selected cycle
      if (psel) begin
        st_nxt.rdata = hit_hi ? st_r.hi : (hit_lo ? st_r.lo : 16'h0000);
      end
      st_nxt.cap_ok = psel && !acc_done;
      // A write lands only at the completing edge
      if (acc_done && pwrite) begin
        if (hit_hi) begin
          st_nxt.hi = merge(pwdata[15:0], `PAFS_HI_WMASK, `PAFS_HI_ONES);
        end
        if (hit_lo) begin
          st_nxt.lo = merge(pwdata[15:0], `PAFS_LO_WMASK, `PAFS_LO_ONES);
        end
      end
    end
  end

  // State register; reset to the power-on mode values
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r.hi     <= `PAFS_HI_RST;
      st_r.lo     <= `PAFS_LO_RST;
      st_r.rdata  <= 16'h0000;
      st_r.cap_ok <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Pin routing: gpio pins follow port data and direction
  always_comb begin
    pafs_word_t o;
    pafs_word_t e;
    pafs_word_t s;
    o = '0;
    e = '0;
    s = pins.in_sync;
    // Reserved codes release the pin
    unique case (fld(st_r.hi, `PAFS_P15_LSB))
      PAFS_M_GPIO: begin o[15] = port_data[15]; e[15] = port_dir[15]; end
      default:     ;
    endcase
    unique case (fld(st_r.hi, `PAFS_P14_LSB))
      PAFS_M_GPIO: begin o[14] = port_data[14]; e[14] = port_dir[14]; end
      PAFS_M_ALT3: begin o[14] = dma_ack_1; e[14] = 1'b1; end
      default:     ;
    endcase
    unique case (fld(st_r.hi, `PAFS_P13_LSB))
      PAFS_M_GPIO: begin o[13] = port_data[13]; e[13] = port_dir[13]; end
      default:     ;
    endcase
    unique case (fld(st_r.hi, `PAFS_P12_LSB))
      PAFS_M_GPIO: begin o[12] = port_data[12]; e[12] = port_dir[12]; end
      PAFS_M_ALT3: begin o[12] = dma_ack_0; e[12] = 1'b1; end
      default:     ;
    endcase
    unique case (fld(st_r.hi, `PAFS_P11_LSB))
      PAFS_M_GPIO: begin o[11] = port_data[11]; e[11] = port_dir[11]; end
      PAFS_M_ALT1: begin o[11] = upper_parity_out; e[11] = upper_parity_oe; end
      PAFS_M_ALT2: begin o[11] = timer_cc_b1_out; e[11] = timer_cc_b1_oe; end
      default:     ;
    endcase
    unique case (fld(st_r.hi, `PAFS_P10_LSB))
      PAFS_M_GPIO: begin o[10] = port_data[10]; e[10] = port_dir[10]; end
      PAFS_M_ALT1: begin o[10] = lower_parity_out; e[10] = lower_parity_oe; end
      PAFS_M_ALT2: begin o[10] = timer_cc_a1_out; e[10] = timer_cc_a1_oe; end
      default:     ;
    endcase
    unique case (fld(st_r.hi, `PAFS_P9_LSB))
      PAFS_M_GPIO: begin o[9] = port_data[9]; e[9] = port_dir[9]; end
      PAFS_M_ALT1: begin o[9] = address_hold_out; e[9] = 1'b1; end
      PAFS_M_ALT3: begin o[9] = int_request_out; e[9] = 1'b1; end
      default:     ;
    endcase
    // Pin 8 carries an input only when selected
    if (!st_r.hi[`PAFS_P8_BIT]) begin
      o[8] = port_data[8];
      e[8] = port_dir[8];
    end
    // Single-bit output functions of the low register
    if (st_r.lo[`PAFS_P7_BIT]) begin
      o[7] = bus_grant_out;
      e[7] = 1'b1;
    end else begin
      o[7] = port_data[7];
      e[7] = port_dir[7];
    end
    if (st_r.lo[`PAFS_P6_BIT]) begin
      o[6] = read_strobe_out;
      e[6] = 1'b1;
    end else begin
      o[6] = port_data[6];
      e[6] = port_dir[6];
    end
    // The strobe mode itself is chosen by the bus controller
    if (st_r.lo[`PAFS_P5_BIT]) begin
      o[5] = high_lane_store_strobe;
      e[5] = 1'b1;
    end else begin
      o[5] = port_data[5];
      e[5] = port_dir[5];
    end
    if (st_r.lo[`PAFS_P4_BIT]) begin
      o[4] = low_lane_store_strobe;
      e[4] = 1'b1;
    end else begin
      o[4] = port_data[4];
      e[4] = port_dir[4];
    end
    unique case (fld(st_r.lo, `PAFS_P3_LSB))
      PAFS_M_GPIO: begin o[3] = port_data[3]; e[3] = port_dir[3]; end
      PAFS_M_ALT1: begin o[3] = chip_sel_7; e[3] = 1'b1; end
      default:     ;
    endcase
    unique case (fld(st_r.lo, `PAFS_P2_LSB))
      PAFS_M_GPIO: begin o[2] = port_data[2]; e[2] = port_dir[2]; end
      PAFS_M_ALT1: begin o[2] = chip_sel_6; e[2] = 1'b1; end
      PAFS_M_ALT2: begin o[2] = timer_cc_b0_out; e[2] = timer_cc_b0_oe; end
      default:     ;
    endcase
    unique case (fld(st_r.lo, `PAFS_P1_LSB))
      PAFS_M_GPIO: begin o[1] = port_data[1]; e[1] = port_dir[1]; end
      PAFS_M_ALT1: begin o[1] = chip_sel_5; e[1] = 1'b1; end
      PAFS_M_ALT2: begin o[1] = row_addr_strobe; e[1] = 1'b1; end
      default:     ;
    endcase
    unique case (fld(st_r.lo, `PAFS_P0_LSB))
      PAFS_M_GPIO: begin o[0] = port_data[0]; e[0] = port_dir[0]; end
      PAFS_M_ALT1: begin o[0] = chip_sel_4; e[0] = 1'b1; end
      PAFS_M_ALT2: begin o[0] = timer_cc_a0_out; e[0] = timer_cc_a0_oe; end
      default:     ;
    endcase
    pins.drv_out = o;
    pins.drv_oe  = e;
    // Peripheral inputs: pin level when selected, idle level otherwise
    ext_int_3       = (fld(st_r.hi, `PAFS_P15_LSB) == PAFS_M_ALT1) ? s[15] : `PAFS_IN_IDLE;
    dma_req_1       = (fld(st_r.hi, `PAFS_P15_LSB) == PAFS_M_ALT3) ? s[15] : `PAFS_IN_IDLE;
    ext_int_2       = (fld(st_r.hi, `PAFS_P14_LSB) == PAFS_M_ALT1) ? s[14] : `PAFS_IN_IDLE;
    ext_int_1       = (fld(st_r.hi, `PAFS_P13_LSB) == PAFS_M_ALT1) ? s[13] : `PAFS_IN_IDLE;
    timer_ext_clk_b = (fld(st_r.hi, `PAFS_P13_LSB) == PAFS_M_ALT2) ? s[13] : `PAFS_IN_IDLE;
    dma_req_0       = (fld(st_r.hi, `PAFS_P13_LSB) == PAFS_M_ALT3) ? s[13] : `PAFS_IN_IDLE;
    ext_int_0       = (fld(st_r.hi, `PAFS_P12_LSB) == PAFS_M_ALT1) ? s[12] : `PAFS_IN_IDLE;
    timer_ext_clk_a = (fld(st_r.hi, `PAFS_P12_LSB) == PAFS_M_ALT2) ? s[12] : `PAFS_IN_IDLE;
    upper_parity_in = (fld(st_r.hi, `PAFS_P11_LSB) == PAFS_M_ALT1) ? s[11] : `PAFS_IN_IDLE;
    timer_cc_b1_in  = (fld(st_r.hi, `PAFS_P11_LSB) == PAFS_M_ALT2) ? s[11] : `PAFS_IN_IDLE;
    lower_parity_in = (fld(st_r.hi, `PAFS_P10_LSB) == PAFS_M_ALT1) ? s[10] : `PAFS_IN_IDLE;
    timer_cc_a1_in  = (fld(st_r.hi, `PAFS_P10_LSB) == PAFS_M_ALT2) ? s[10] : `PAFS_IN_IDLE;
    conv_trigger_in = (fld(st_r.hi, `PAFS_P9_LSB) == PAFS_M_ALT2) ? s[9] : `PAFS_IN_IDLE;
    bus_req_in      = st_r.hi[`PAFS_P8_BIT] ? s[8] : `PAFS_IN_IDLE;
    wait_in         = (fld(st_r.lo, `PAFS_P3_LSB) == PAFS_M_ALT2) ? s[3] : `PAFS_IN_IDLE;
    timer_cc_b0_in  = (fld(st_r.lo, `PAFS_P2_LSB) == PAFS_M_ALT2) ? s[2] : `PAFS_IN_IDLE;
    timer_cc_a0_in  = (fld(st_r.lo, `PAFS_P0_LSB) == PAFS_M_ALT2) ? s[0] : `PAFS_IN_IDLE;
  end

  // Pad ring: synchroniser and registered drivers
  pafs_pad_stage u_pad (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .pad_in  (pad_in),
    .pad_out (pad_out),
    .pad_oe  (pad_oe),
    .core    (pins.pad)
  );

  // Checks on pin routing and register behaviour
  property p_p15_dreq;
    @(posedge pclk) disable iff (!presetn)
      (st_r.hi[15:14] == 2'h3) |-> (dma_req_1 == pins.in_sync[15]) && (ext_int_3 == `PAFS_IN_IDLE);
  endproperty
  a_p15_dreq: assert property (p_p15_dreq) else $error("pin 15 request not routed");

  property p_p14_dack;
    @(posedge pclk) disable iff (!presetn)
      (ce && st_r.hi[13:12] == 2'h3) |=> pad_oe[14] && (pad_out[14] == $past(dma_ack_1));
  endproperty
  a_p14_dack: assert property (p_p14_dack) else $error("pin 14 acknowledge not driven");

  property p_p13_clkb;
    @(posedge pclk) disable iff (!presetn)
      (st_r.hi[11:10] == 2'h2) |-> (timer_ext_clk_b == pins.in_sync[13]) && (dma_req_0 == `PAFS_IN_IDLE);
  endproperty
  a_p13_clkb: assert property (p_p13_clkb) else $error("pin 13 clock input wrong");

  property p_p12_int;
    @(posedge pclk) disable iff (!presetn)
      (st_r.hi[9:8] != 2'h1) |-> (ext_int_0 == `PAFS_IN_IDLE);
  endproperty
  a_p12_int: assert property (p_p12_int) else $error("pin 12 interrupt not idle");

  property p_p11_timer;
    @(posedge pclk) disable iff (!presetn)
      (ce && st_r.hi[7:6] == 2'h2) |=> (pad_oe[11] == $past(timer_cc_b1_oe));
  endproperty
  a_p11_timer: assert property (p_p11_timer) else $error("pin 11 timer enable wrong");

  property p_p9_irq;
    @(posedge pclk) disable iff (!presetn)
      (ce && st_r.hi[3:2] == 2'h3) |=> pad_oe[9] && (pad_out[9] == $past(int_request_out));
  endproperty
  a_p9_irq: assert property (p_p9_irq) else $error("pin 9 request output wrong");

  property p_p8_busreq;
    @(posedge pclk) disable iff (!presetn)
      !st_r.hi[0] |-> (bus_req_in == `PAFS_IN_IDLE);
  endproperty
  a_p8_busreq: assert property (p_p8_busreq) else $error("pin 8 request not idle");

  property p_p7_write;
    @(posedge pclk) disable iff (!presetn)
      (ce && psel && penable && pready && pwrite && hit_lo && !pwdata[14])
        |=> !st_r.lo[14] ##1 (!$past(ce) ||
            (pad_oe[7] == $past(port_dir[7]) && pad_out[7] == $past(port_data[7])));
  endproperty
  a_p7_write: assert property (p_p7_write) else $error("pin 7 mode write lost");

  property p_p6_gpio;
    @(posedge pclk) disable iff (!presetn)
      (ce && !st_r.lo[12] && port_dir[6]) |=> pad_oe[6] && (pad_out[6] == $past(port_data[6]));
  endproperty
  a_p6_gpio: assert property (p_p6_gpio) else $error("pin 6 gpio output wrong");

  property p_p3_wait;
    @(posedge pclk) disable iff (!presetn)
      (ce && st_r.lo[7:6] == 2'h2) |-> (wait_in == pins.in_sync[3]) ##1 !pad_oe[3];
  endproperty
  a_p3_wait: assert property (p_p3_wait) else $error("pin 3 wait input wrong");

  property p_lo_ones;
    @(posedge pclk) disable iff (!presetn)
      (ce && psel && hit_lo) |=> (prdata[15] && prdata[13] && prdata[11] && prdata[9]);
  endproperty
  a_lo_ones: assert property (p_lo_ones) else $error("low register odd bits not one");

  // Main scenarios
  c_hi_write: cover property (@(posedge pclk) disable iff (!presetn)
    acc_done && pwrite && hit_hi);
  c_p9_irq: cover property (@(posedge pclk) disable iff (!presetn)
    st_r.hi[3:2] == 2'h3);
  c_gpio_out: cover property (@(posedge pclk) disable iff (!presetn)
    st_r.lo[1:0] == 2'h0 && port_dir[0]);

endmodule : pafs_top
`default_nettype wire

/* File: rtl/pafs_map.svh */
`ifndef PAFS_MAP_SVH
`define PAFS_MAP_SVH

// Register indices; byte address is four times the index
`define PAFS_HI_IDX      30'h05FFFFC8
`define PAFS_LO_IDX      30'h05FFFFCA

// Reset values
`define PAFS_HI_RST      16'h3302
`define PAFS_LO_RST      16'hFF95

// Writable bits and bits that always read as one
`define PAFS_HI_WMASK    16'hFFFD
`define PAFS_HI_ONES     16'h0002
`define PAFS_LO_WMASK    16'h55FF
`define PAFS_LO_ONES     16'hAA00

// Field positions, high register (lsb of each two-bit field; pin 8 is a single bit)
`define PAFS_P15_LSB     14
`define PAFS_P14_LSB     12
`define PAFS_P13_LSB     10
`define PAFS_P12_LSB     8
`define PAFS_P11_LSB     6
`define PAFS_P10_LSB     4
`define PAFS_P9_LSB      2
`define PAFS_P8_BIT      0

// Field positions, low register
`define PAFS_P7_BIT      14
`define PAFS_P6_BIT      12
`define PAFS_P5_BIT      10
`define PAFS_P4_BIT      8
`define PAFS_P3_LSB      6
`define PAFS_P2_LSB      4
`define PAFS_P1_LSB      2
`define PAFS_P0_LSB      0

// Level a peripheral input sees while its pin is not selected
`define PAFS_IN_IDLE     1'b1

`endif

/* File: rtl/pafs_pkg.sv */
package pafs_pkg;

  // One port-wide vector
  typedef logic [15:0] pafs_word_t;

  // Two-bit mode codes
  typedef enum logic [1:0] {
    PAFS_M_GPIO,
    PAFS_M_ALT1,
    PAFS_M_ALT2,
    PAFS_M_ALT3
  } pafs_mode_e;

  // Register-side state of the top module
  typedef struct packed {
    pafs_word_t hi;      // High control register
    pafs_word_t lo;      // Low control register
    pafs_word_t rdata;   // Captured read data
    logic       cap_ok;  // Read data captured for this transfer
  } pafs_regs_s;

  // Pad stage state
  typedef struct packed {
    pafs_word_t meta;    // First synchroniser stage
    pafs_word_t sync;    // Second synchroniser stage
    pafs_word_t out;     // Registered pad level
    pafs_word_t oe;      // Registered pad enable
  } pafs_pad_s;

endpackage : pafs_pkg

/* File: rtl/pafs_pad_if.sv */
`timescale 1ns/10ps
`default_nettype none
// Core-to-pad bundle of the port
interface pafs_pad_if;
  import pafs_pkg::*;
  pafs_word_t drv_out;   // Level each pin should carry
  pafs_word_t drv_oe;    // High where the pin is driven
  pafs_word_t in_sync;   // Synchronised pin levels

  modport core (output drv_out, output drv_oe, input in_sync);
  modport pad  (input drv_out, input drv_oe, output in_sync);
endinterface : pafs_pad_if
`default_nettype wire

/* File: rtl/pafs_pad_stage.sv */
`timescale 1ns/10ps
`default_nettype none
// Pad ring of port A: input synchroniser and registered drivers
module pafs_pad_stage (
  // Clock, reset, enable
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          ce,
  // Pins
  input  wire pafs_pkg::pafs_word_t pad_in,
  output var  pafs_pkg::pafs_word_t pad_out,
  output var  pafs_pkg::pafs_word_t pad_oe,
  // Core side
  pafs_pad_if.pad            core
);
  import pafs_pkg::*;

  pafs_pad_s st_r;   // All state
  pafs_pad_s st_nxt; // Next state

  // Next state; frozen while the enable is low
  always_comb begin
    st_nxt = st_r;
    if (ce) begin
      st_nxt.meta = pad_in;
      st_nxt.sync = st_r.meta;
      st_nxt.out  = core.drv_out;
      st_nxt.oe   = core.drv_oe;
    end
  end

  // State register; pins released during reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Only the second stage is seen by the core
  assign core.in_sync = st_r.sync;
  assign pad_out      = st_r.out;
  assign pad_oe       = st_r.oe;

endmodule : pafs_pad_stage
`default_nettype wire

/* File: tb/pafs_top_tb.sv */
`timescale 1ns/10ps
`default_nettype none
// Self-checking bench for the port A pin function select block
module pafs_top_tb;
  import pafs_pkg::*;

  // Register byte addresses, four times the register indices
  localparam logic [31:0] A_HI = 32'h17FFFF20;
  localparam logic [31:0] A_LO = 32'h17FFFF28;
  // Table rows: address, written word, expected readback
  localparam logic [31:0] RA[6] = '{A_HI, A_HI, A_HI, A_LO, A_LO, A_LO};
  localparam logic [31:0] RW[6] = '{32'hFFFF, 32'h0, 32'h5555, 32'h0, 32'hFFFF, 32'h5555};
  localparam logic [31:0] RE[6] = '{32'hFFFF, 32'h2, 32'h5557, 32'hAA00, 32'hFFFF, 32'hFF55};

  logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
  logic [31:0] paddr, pwdata, prdata;
  pafs_word_t  port_data, port_dir, pad_in, pad_out, pad_oe;
  // Peripheral inputs seen by the device
  logic ext_int_0, ext_int_1, ext_int_2, ext_int_3, dma_req_0, dma_req_1;
  logic timer_ext_clk_a, timer_ext_clk_b, conv_trigger_in, bus_req_in, wait_in;
  logic upper_parity_in, lower_parity_in, timer_cc_a0_in, timer_cc_b0_in;
  logic timer_cc_a1_in, timer_cc_b1_in;
  // Peripheral outputs and two-way halves
  logic dma_ack_0, dma_ack_1, address_hold_out, int_request_out, bus_grant_out;
  logic read_strobe_out, high_lane_store_strobe, low_lane_store_strobe;
  logic chip_sel_4, chip_sel_5, chip_sel_6, chip_sel_7, row_addr_strobe;
  logic upper_parity_out, upper_parity_oe, lower_parity_out, lower_parity_oe;
  logic timer_cc_a0_out, timer_cc_a0_oe, timer_cc_b0_out, timer_cc_b0_oe;
  logic timer_cc_a1_out, timer_cc_a1_oe, timer_cc_b1_out, timer_cc_b1_oe;
  logic [12:0] po;       // Packed peripheral outputs
  logic [11:0] tw;       // Packed two-way out/oe pairs
  logic [16:0] pins_in;  // Packed peripheral inputs
  logic [31:0] rd;       // Last read data
  logic        er;       // Last error response
  int          n_errors, checks_done;

  assign {row_addr_strobe, chip_sel_7, chip_sel_6, chip_sel_5, chip_sel_4,
          low_lane_store_strobe, high_lane_store_strobe, read_strobe_out,
          bus_grant_out, int_request_out, address_hold_out, dma_ack_1, dma_ack_0} = po;
  assign {upper_parity_out, upper_parity_oe, lower_parity_out, lower_parity_oe,
          timer_cc_a0_out, timer_cc_a0_oe, timer_cc_b0_out, timer_cc_b0_oe,
          timer_cc_a1_out, timer_cc_a1_oe, timer_cc_b1_out, timer_cc_b1_oe} = tw;
  assign pins_in = {ext_int_3, ext_int_2, ext_int_1, ext_int_0, dma_req_1, dma_req_0,
                    timer_ext_clk_a, timer_ext_clk_b, conv_trigger_in, bus_req_in, wait_in,
                    upper_parity_in, lower_parity_in, timer_cc_a0_in, timer_cc_b0_in,
                    timer_cc_a1_in, timer_cc_b1_in};

  pafs_top dut (.*);

  // Clock, 40 ns period
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // Compare and count
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", nm, e, g);
      n_errors++;
    end
  endtask : chk

  // One APB transfer; request held until pready is seen high at a rising edge
  task apb(input logic [31:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Answer and read data are taken at the completing edge itself
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Let registered pad and synchroniser stages land
  task settle(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask : settle

  // Verdict and end of run
  task complete_run;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : complete_run

  // Watchdog, well above the roughly 130 cycles the tests need
  initial begin
    repeat (5000) @(posedge pclk);
    n_errors++;
    complete_run();
  end

  // Main sequence
  initial begin
    n_errors = 0;
    checks_done = 0;
    presetn = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    port_data = 16'hA5C3;
    port_dir = 16'h0000;
    pad_in = 16'h0000;
    po = 13'h0555;
    tw = 12'h000;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    // Reset values and reset routing
    apb(A_HI, 1'b0, 32'h0);
    chk("hi reset", 32'h3302, rd);
    apb(A_LO, 1'b0, 32'h0);
    chk("lo reset", 32'hFF95, rd);
    settle(1);
    chk("reset oe", 16'h50F7, pad_oe);
    chk("reset out", 16'h10A5, pad_out & 16'h50F7);
    $display("test reset done");
    // Table of writes and readbacks, read-only ones included
    for (int i = 0; i < 6; i++) begin
      apb(RA[i], 1'b1, RW[i]);
      apb(RA[i], 1'b0, 32'h0);
      chk("readback", RE[i], rd);
    end
    $display("test registers done");
    // All pins general I/O and driven as outputs
    apb(A_HI, 1'b1, 32'h0);
    apb(A_LO, 1'b1, 32'h0);
    port_dir <= 16'hFFFF;
    settle(3);
    chk("gpio oe", 16'hFFFF, pad_oe);
    chk("gpio out", 16'hA5C3, pad_out);
    // Reserved codes release their pins, inputs idle
    apb(A_HI, 1'b1, 32'h8000);
    apb(A_LO, 1'b1, 32'h00FF);
    settle(4);
    chk("reserved oe", 16'h7FF0, pad_oe);
    chk("reserved in", 17'h1FFFF, pins_in);
    $display("test reserved done");
    // Input functions, first set
    apb(A_HI, 1'b1, 32'h4909);
    port_dir <= 16'h0000;
    apb(A_LO, 1'b1, 32'h0080);
    settle(4);
    chk("inputs a", 17'h0DC3F, pins_in);
    // A selected input follows its own pin through the synchroniser
    @(posedge pclk);
    pad_in <= 16'h1000;
    settle(3);
    chk("pin level a", 17'h0FC3F, pins_in);
    // Second set plus output functions
    apb(A_HI, 1'b1, 32'hDE9C);
    pad_in <= 16'h0000;
    apb(A_LO, 1'b1, 32'h006A);
    po <= 13'h1AAA;
    settle(4);
    chk("inputs b", 17'h163E2, pins_in);
    chk("outputs oe", 16'h020A, pad_oe);
    chk("outputs out", 16'h020A, pad_out & 16'h020A);
    // Two-way lines drive their pins when enabled
    @(posedge pclk);
    tw <= 12'hFFF;
    settle(3);
    chk("two-way oe", 16'h0E0F, pad_oe);
    chk("two-way out", 16'h0E0F, pad_out & 16'h0E0F);
    // Clock enable low freezes the pad drivers
    @(posedge pclk);
    ce <= 1'b0;
    tw <= 12'h000;
    settle(3);
    chk("frozen oe", 16'h0E0F, pad_oe);
    @(posedge pclk);
    ce <= 1'b1;
    settle(2);
    chk("thawed oe", 16'h020A, pad_oe);
    $display("test routing done");
    // Unmapped word gives an error and zero data
    apb(32'h17FFFF24, 1'b0, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, er});
    chk("unmapped data", 32'h0, rd);
    // Reset in mid-run restores the defaults
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("pads in reset", 32'h0, pad_oe);
    presetn <= 1'b1;
    apb(A_HI, 1'b0, 32'h0);
    chk("hi re-reset", 32'h3302, rd);
    settle(1);
    chk("re-reset oe", 16'h50F7, pad_oe);
    $display("test error and reset done");
    complete_run();
  end
endmodule : pafs_top_tb
`default_nettype wire
